// file: pkg/control_drive_strength_cfg_pkg.sv
// constants for the memory controller configuration block
package control_drive_strength_cfg_pkg;
  // ****************************************
  // register offsets and reset values
  // ****************************************
  localparam logic [15:0] OFF_CTRL_ONE   = 16'h8400;
  localparam logic [15:0] OFF_CTRL_TWO   = 16'h8404;
  localparam logic [15:0] OFF_BANK_CFG   = 16'h8408;
  localparam logic [15:0] OFF_TIMING_ONE = 16'h840c;
  localparam logic [15:0] OFF_GFX_BASE   = 16'h8414;
  localparam logic [15:0] OFF_DIRTY_IDX  = 16'h8418;
  localparam logic [15:0] OFF_DIRTY_ACC  = 16'h841c;
  localparam logic [31:0] RST_CTRL_ONE   = 32'h248c0040;
  localparam logic [31:0] RST_CTRL_TWO   = 32'h00000801;
  localparam logic [31:0] RST_BANK_CFG   = 32'h41104110;
  localparam logic [31:0] RST_TIMING_ONE = 32'h2a733225;
  localparam logic [31:0] RST_ZERO       = 32'h00000000;
  // ****************************************
  // field positions
  // ****************************************
  localparam int DATA_DRV_LSB   = 30;
  localparam int ADDR_DRV_LSB   = 27;
  localparam int CTRL_DRV_LSB   = 24;
  localparam int RATIO_LSB      = 18;
  localparam int RESTART_BIT    = 17;
  localparam int RFSH_INT_LSB   = 8;
  localparam int RFSH_INT_W     = 9;
  localparam int STAGGER_LSB    = 6;
  localparam int ADDR_SETUP_BIT = 5;
  localparam int TEST_RFSH_BIT  = 4;
  localparam int ROUND_ROBIN_BIT = 3;
  localparam int SYSMGMT_REGION_MAP_BIT    = 2;
  localparam int MODE_PROG_BIT  = 0;
  localparam int CLKCTL_LSB     = 12;
  localparam int CLK_MASK_LSB   = 6;
  localparam int NUM_CLK_OUT    = 5;
  localparam int SHIFT_LSB      = 3;
  localparam int READ_PHASE_BIT = 1;
  localparam int FAST_RD_BIT    = 0;
  localparam int MOD_BANKS_BIT  = 14;
  localparam int COMP_BANKS_BIT = 12;
  localparam int CAS_LAT_LSB    = 28;
  // ****************************************
  // codes and windows
  // ****************************************
  localparam logic [2:0]  RATIO_RSVD   = 3'h0;
  localparam logic [2:0]  SHIFT_RSVD   = 3'h7;
  localparam logic [31:0] SMM_WIN_BASE = 32'h00400000;
  localparam logic [31:0] SMM_WIN_SIZE = 32'h00020000;
  localparam logic [31:0] SMM_PHYS_LO  = 32'h000a0000;
  localparam logic [31:0] SMM_PHYS_HI  = 32'h000bffff;
  typedef enum logic [1:0] {REQ_CPU, REQ_GFX, REQ_DISP_LO} req_src_e;
  typedef enum {RF_IDLE, RF_BANK, RF_GAP} rfsh_state_e;
endpackage

// file: logic/sdclk_gen.sv
// sdram clock enable generator: half-core-clock ratio and phase counter
module sdclk_gen
  import control_drive_strength_cfg_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic       restart_i,
  input  wire logic [2:0] ratio_i,
  input  wire logic [2:0] shift_i,
  output logic            running_o,
  output logic            sdclk_rise_o,
  output logic [3:0]      half_period_o
);
  // ****************************************
  // half-step accounting
  // ****************************************
  // the clock advances in half core clocks, so the divider counts two half-steps per core clock
  logic [3:0] period_half_q;
  logic [3:0] phase_q;
  logic [3:0] delay_q;
  logic       running_q;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      period_half_q <= 4'h6;
      delay_q       <= 4'h0;
      phase_q       <= 4'h0;
      running_q     <= 1'b0;
    end else if (restart_i) begin
      // reserved codes fall back to the default ratio / no shift
      period_half_q <= (ratio_i == RATIO_RSVD) ? 4'h6 : {1'b0, ratio_i} + 4'h3;
      delay_q       <= (shift_i == SHIFT_RSVD) ? 4'h0 : {1'b0, shift_i};
      phase_q       <= 4'h0;
      running_q     <= 1'b1;
    end else if (delay_q > 4'h1) begin
      delay_q <= delay_q - 4'h2;
    end else if (delay_q == 4'h1) begin
      delay_q <= 4'h0;
      phase_q <= 4'h1;
    end else if (running_q) begin
      phase_q <= (phase_q + 4'h2 >= period_half_q) ? phase_q + 4'h2 - period_half_q : phase_q + 4'h2;
    end
  end

  assign running_o     = running_q;
  assign sdclk_rise_o  = running_q && delay_q == 4'h0 && phase_q < 4'h2;
  assign half_period_o = period_half_q;
endmodule

// file: logic/control_drive_strength_cfg.sv
// memory controller configuration, refresh, arbitration and mapping logic
// Function
// - two-bit drive strengths, 11 strongest, 00 weakest
// - ratio field divides core clock, 000 reserved
// - new ratio waits for restart rising edge
// - restart 0-to-1 starts clock with new settings
// - interval resets zero; zero disables refresh
// - stagger 0/1/2/4 clocks, one bank at time
// - extended setup drives address one clock early
// - test bit generates a refresh request
// - round robin equal, else processor wins
// - high-priority display always granted first
// - smm window redirected to a0000-bffff
// - mode bit 0-to-1 issues mode register set
// - five active-high clock output mask bits
// - shift in half core clocks, 111 reserved
// - read phase selects one or two clocks
// - fast-read mask blocks fifo bypass
// - module banks bit selects one or two
module control_drive_strength_cfg
  import control_drive_strength_cfg_pkg::*;
#(
  parameter int NUM_BANKS = 2
)
(
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic [31:0]      reg_rdata_o,
  input  wire logic        req_cpu_i,
  input  wire logic        req_gfx_i,
  input  wire logic        req_disp_lo_i,
  input  wire logic        req_disp_hi_i,
  output logic [3:0]       grant_o,
  input  wire logic [31:0] access_addr_i,
  output logic [31:0]      phys_addr_o,
  input  wire logic        cmd_start_i,
  output logic             cs_allow_o,
  input  wire logic        read_bypass_i,
  output logic             read_bypass_ok_o,
  output logic             read_capture_o,
  output logic             rfsh_pending_o,
  output logic [NUM_BANKS-1:0] rfsh_bank_o,
  input  wire logic        rfsh_done_i,
  output logic             mode_set_o,
  output logic [2:0]       cas_latency_o,
  output logic             sdclk_run_o,
  output logic             sdclk_rise_o,
  output logic [NUM_CLK_OUT-1:0] clk_out_en_o,
  output logic [1:0]       data_drive_strength_o,
  output logic [1:0]       address_bank_drive_strength_o,
  output logic [1:0]       control_drive_strength_o,
  output logic [1:0]       memory_clock_drive_strength_o,
  output logic             two_module_banks_o,
  output logic             one_component_bank_o
);
  // ****************************************
  // register file
  // ****************************************
  logic [31:0] ctrl_one_q, ctrl_two_q, bank_cfg_q, timing_q, gfx_q, dirty_idx_q, dirty_acc_q;
  logic        restart_prev_q, mode_prev_q;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_one_q  <= RST_CTRL_ONE;
      ctrl_two_q  <= RST_CTRL_TWO;
      bank_cfg_q  <= RST_BANK_CFG;
      timing_q    <= RST_TIMING_ONE;
      gfx_q       <= RST_ZERO;
      dirty_idx_q <= RST_ZERO;
      dirty_acc_q <= RST_ZERO;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        OFF_CTRL_ONE:   ctrl_one_q  <= reg_wdata_i;
        OFF_CTRL_TWO:   ctrl_two_q  <= reg_wdata_i;
        OFF_BANK_CFG:   bank_cfg_q  <= reg_wdata_i;
        OFF_TIMING_ONE: timing_q    <= reg_wdata_i;
        OFF_GFX_BASE:   gfx_q       <= reg_wdata_i;
        OFF_DIRTY_IDX:  dirty_idx_q <= reg_wdata_i;
        OFF_DIRTY_ACC:  dirty_acc_q <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  always_comb begin
    reg_rdata_o = 32'h00000000;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFF_CTRL_ONE:   reg_rdata_o = ctrl_one_q;
        OFF_CTRL_TWO:   reg_rdata_o = ctrl_two_q;
        OFF_BANK_CFG:   reg_rdata_o = bank_cfg_q;
        OFF_TIMING_ONE: reg_rdata_o = timing_q;
        OFF_GFX_BASE:   reg_rdata_o = gfx_q;
        OFF_DIRTY_IDX:  reg_rdata_o = dirty_idx_q;
        OFF_DIRTY_ACC:  reg_rdata_o = dirty_acc_q;
        default:        reg_rdata_o = 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // static settings
  // ****************************************
  assign data_drive_strength_o         = ctrl_one_q[DATA_DRV_LSB +: 2];
  assign address_bank_drive_strength_o = ctrl_one_q[ADDR_DRV_LSB +: 2];
  assign control_drive_strength_o      = ctrl_one_q[CTRL_DRV_LSB +: 2];
  assign memory_clock_drive_strength_o = ctrl_two_q[CLKCTL_LSB +: 2];
  assign two_module_banks_o            = bank_cfg_q[MOD_BANKS_BIT];
  assign one_component_bank_o          = bank_cfg_q[COMP_BANKS_BIT];
  assign read_bypass_ok_o = read_bypass_i && !ctrl_two_q[FAST_RD_BIT];

  // ****************************************
  // edge triggers
  // ****************************************
  // edges are seen on the stored bit, so a write of 1 over 1 never triggers
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      restart_prev_q <= 1'b0;
      mode_prev_q    <= 1'b0;
    end else begin
      restart_prev_q <= ctrl_one_q[RESTART_BIT];
      mode_prev_q    <= ctrl_one_q[MODE_PROG_BIT];
    end
  end
  logic restart_rise, mode_rise;
  assign restart_rise = ctrl_one_q[RESTART_BIT] && !restart_prev_q;
  assign mode_rise    = ctrl_one_q[MODE_PROG_BIT] && !mode_prev_q;
  logic mode_q;
  logic [2:0] cas_q;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q <= 1'b0;
      cas_q  <= 3'h0;
    end else begin
      mode_q <= mode_rise;
      if (mode_rise) cas_q <= timing_q[CAS_LAT_LSB +: 3];
    end
  end
  assign mode_set_o    = mode_q;
  assign cas_latency_o = cas_q;
  // ****************************************
  // sdram clock
  // ****************************************
  logic sd_rise;
  sdclk_gen u_sdclk (
    .clock_i       (clock_i),
    .rstn_i        (rstn_i),
    .restart_i     (restart_rise),
    .ratio_i       (ctrl_one_q[RATIO_LSB +: 3]),
    .shift_i       (ctrl_two_q[SHIFT_LSB +: 3]),
    .running_o     (sdclk_run_o),
    .sdclk_rise_o  (sd_rise),
    .half_period_o ()
  );
  assign sdclk_rise_o = sd_rise;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CLK_OUT; gi++) begin : g_clk_en
      assign clk_out_en_o[gi] = sdclk_run_o && !ctrl_two_q[CLK_MASK_LSB + gi];
    end
  endgenerate
  // read capture one or two core clocks after the rise
  logic [1:0] rise_dly_q;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) rise_dly_q <= 2'b00;
    else rise_dly_q <= {rise_dly_q[0], sd_rise};
  end
  assign read_capture_o = ctrl_two_q[READ_PHASE_BIT] ? rise_dly_q[1] : rise_dly_q[0];
  // ****************************************
  // address setup
  // ****************************************
  logic setup_q;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) setup_q <= 1'b0;
    else setup_q <= cmd_start_i;
  end
  // chip select held back one clock while the address is already driven
  assign cs_allow_o = ctrl_one_q[ADDR_SETUP_BIT] ? setup_q : cmd_start_i;
  // ****************************************
  // smm mapping
  // ****************************************
  logic in_smm;
  assign in_smm = access_addr_i >= SMM_WIN_BASE && access_addr_i < SMM_WIN_BASE + SMM_WIN_SIZE;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) phys_addr_o <= 32'h00000000;
    else if (ctrl_one_q[SYSMGMT_REGION_MAP_BIT] && in_smm) phys_addr_o <= access_addr_i - SMM_WIN_BASE + SMM_PHYS_LO;
    else phys_addr_o <= access_addr_i;
  end
  // ****************************************
  // arbitration
  // ****************************************
  req_src_e last_q;
  logic [3:0] grant_d;
  always_comb begin
    grant_d = 4'h0;
    if (req_disp_hi_i) grant_d = 4'b1000;
    else if (!ctrl_one_q[ROUND_ROBIN_BIT]) begin
      if (req_cpu_i) grant_d = 4'b0001;
      else if (req_gfx_i) grant_d = 4'b0010;
      else if (req_disp_lo_i) grant_d = 4'b0100;
    end else begin
      unique case (last_q)
        REQ_CPU:     grant_d = req_gfx_i ? 4'b0010 : req_disp_lo_i ? 4'b0100 : req_cpu_i ? 4'b0001 : 4'h0;
        REQ_GFX:     grant_d = req_disp_lo_i ? 4'b0100 : req_cpu_i ? 4'b0001 : req_gfx_i ? 4'b0010 : 4'h0;
        REQ_DISP_LO: grant_d = req_cpu_i ? 4'b0001 : req_gfx_i ? 4'b0010 : req_disp_lo_i ? 4'b0100 : 4'h0;
        default:     grant_d = 4'h0;
      endcase
    end
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) last_q <= REQ_DISP_LO;
    else if (grant_d[0]) last_q <= REQ_CPU;
    else if (grant_d[1]) last_q <= REQ_GFX;
    else if (grant_d[2]) last_q <= REQ_DISP_LO;
  end
  assign grant_o = grant_d;
  // ****************************************
  // refresh timer and staggered sequencer
  // ****************************************
  logic [RFSH_INT_W-1:0] interval, timer_q;
  logic test_prev_q, post_req, req_q;
  assign interval = ctrl_one_q[RFSH_INT_LSB +: RFSH_INT_W];
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      timer_q     <= '0;
      test_prev_q <= 1'b0;
    end else begin
      test_prev_q <= ctrl_one_q[TEST_RFSH_BIT];
      if (interval == '0 || timer_q <= 9'h001) timer_q <= interval;
      else timer_q <= timer_q - 9'h001;
    end
  end
  assign post_req = (interval != '0 && timer_q == 9'h001)
                  || (ctrl_one_q[TEST_RFSH_BIT] && !test_prev_q);

  rfsh_state_e st_q;
  logic [NUM_BANKS-1:0] bank_q;
  logic [2:0] gap_q;
  logic [2:0] gap_len;
  always_comb begin
    unique case (ctrl_one_q[STAGGER_LSB +: 2])
      2'b00: gap_len = 3'h0;
      2'b01: gap_len = 3'h1;
      2'b10: gap_len = 3'h2;
      2'b11: gap_len = 3'h4;
    endcase
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q   <= RF_IDLE;
      bank_q <= '0;
      gap_q  <= 3'h0;
      req_q  <= 1'b0;
    end else begin
      // a request arriving mid-sequence is held, never lost
      if (post_req) req_q <= 1'b1;
      unique case (st_q)
        RF_IDLE: if (req_q || post_req) begin
          req_q  <= 1'b0;
          bank_q <= {{(NUM_BANKS-1){1'b0}}, 1'b1};
          st_q   <= RF_BANK;
        end
        RF_BANK: if (rfsh_done_i) begin
          if (bank_q[NUM_BANKS-1]) st_q <= RF_IDLE;
          else begin
            gap_q <= gap_len;
            st_q  <= RF_GAP;
          end
        end
        RF_GAP: if (gap_q == 3'h0) begin
          bank_q <= bank_q << 1;
          st_q   <= RF_BANK;
        end else if (sd_rise) gap_q <= gap_q - 3'h1;
      endcase
    end
  end
  assign rfsh_pending_o = st_q == RF_BANK;
  assign rfsh_bank_o    = st_q == RF_BANK ? bank_q : '0;
  // ****************************************
  // checks
  // ****************************************
  property p_hi_disp;
    @(posedge clock_i) disable iff (!rstn_i) req_disp_hi_i |-> grant_o == 4'b1000;
  endproperty
  a_hi_disp: assert property (p_hi_disp) else $error("high display not granted");
  property p_cpu_first;
    @(posedge clock_i) disable iff (!rstn_i)
      (!req_disp_hi_i && req_cpu_i && !ctrl_one_q[ROUND_ROBIN_BIT]) |-> grant_o[0];
  endproperty
  a_cpu_first: assert property (p_cpu_first) else $error("cpu lost fixed priority");
  sequence s_mode_pulse;
    mode_set_o ##1 !mode_set_o;
  endsequence
  property p_mode;
    @(posedge clock_i) disable iff (!rstn_i) $rose(ctrl_one_q[MODE_PROG_BIT]) |=> s_mode_pulse;
  endproperty
  a_mode: assert property (p_mode) else $error("mode set not one pulse");
  property p_no_rfsh_off;
    @(posedge clock_i) disable iff (!rstn_i)
      (interval == '0 && !ctrl_one_q[TEST_RFSH_BIT]) [*2] |-> !post_req;
  endproperty
  a_no_rfsh_off: assert property (p_no_rfsh_off) else $error("refresh while disabled");
  property p_bypass;
    @(posedge clock_i) disable iff (!rstn_i) ctrl_two_q[FAST_RD_BIT] |-> !read_bypass_ok_o;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass while masked");
  property p_capture;
    @(posedge clock_i) disable iff (!rstn_i)
      (sd_rise && !ctrl_two_q[READ_PHASE_BIT]) ##1 !ctrl_two_q[READ_PHASE_BIT] |-> read_capture_o;
  endproperty
  a_capture: assert property (p_capture) else $error("capture phase wrong");
  property p_setup;
    @(posedge clock_i) disable iff (!rstn_i)
      (ctrl_one_q[ADDR_SETUP_BIT] && cmd_start_i && !setup_q) |-> !cs_allow_o;
  endproperty
  a_setup: assert property (p_setup) else $error("chip select too early");
  property p_smm;
    @(posedge clock_i) disable iff (!rstn_i)
      (ctrl_one_q[SYSMGMT_REGION_MAP_BIT] && in_smm) |=> phys_addr_o >= SMM_PHYS_LO && phys_addr_o <= SMM_PHYS_HI;
  endproperty
  a_smm: assert property (p_smm) else $error("smm address not mapped");
  property p_one_bank;
    @(posedge clock_i) disable iff (!rstn_i) $onehot0(rfsh_bank_o);
  endproperty
  a_one_bank: assert property (p_one_bank) else $error("several banks refreshing");
  property p_restart;
    @(posedge clock_i) disable iff (!rstn_i) restart_rise |=> sdclk_run_o;
  endproperty
  a_restart: assert property (p_restart) else $error("clock not started");
endmodule

// file: verif/memory_side_model.sv
// far-side model: answers each bank refresh request after a chosen delay
module memory_side_model (
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic       rfsh_pending_i,
  input  wire logic [3:0] answer_delay_i,
  output logic            rfsh_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // refresh answer
  // ****************************************
  logic [3:0] wait_q;
  // one done pulse per bank; a slow device may take several clocks
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_q      <= 4'h0;
      rfsh_done_o <= 1'b0;
    end else if (!rfsh_pending_i || rfsh_done_o) begin
      wait_q      <= 4'h0;
      rfsh_done_o <= 1'b0;
    end else begin
      rfsh_done_o <= (wait_q == answer_delay_i);
      wait_q      <= wait_q + 4'h1;
    end
  end
endmodule

// file: verif/test_control_drive_strength_cfg.sv
// self-checking bench for the memory controller configuration block
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR %0t got %0h expected %0h", $time, (got), (exp)); end end
module test_control_drive_strength_cfg
  import control_drive_strength_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // stimulus, outputs and counters
  // ****************************************
  logic        clock_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [15:0] reg_addr_i = 16'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] access_addr_i = 32'h0;
  logic        req_cpu_i = 1'b0;
  logic        req_gfx_i = 1'b0;
  logic        req_disp_lo_i = 1'b0;
  logic        req_disp_hi_i = 1'b0;
  logic        cmd_start_i = 1'b0;
  logic        read_bypass_i = 1'b1;
  logic [3:0]  answer_delay = 4'h0;
  logic        rfsh_done_i, cs_allow_o, read_bypass_ok_o, read_capture_o, rfsh_pending_o, mode_set_o;
  logic        sdclk_run_o, sdclk_rise_o, two_module_banks_o, one_component_bank_o;
  logic [31:0] reg_rdata_o, phys_addr_o;
  logic [3:0]  grant_o, seen;
  logic [2:0]  cas_latency_o;
  logic [4:0]  clk_out_en_o;
  logic [1:0]  rfsh_bank_o, data_drive_strength_o, address_bank_drive_strength_o, cb;
  logic [1:0]  control_drive_strength_o, memory_clock_drive_strength_o, pb = 2'b00;
  int          failures = 0;
  int          samples_checked = 0;
  int          r0, r1, bad, gap0, g01, t0, te0, cyc, n, k;

  control_drive_strength_cfg #(.NUM_BANKS(2)) dut (.clock_i, .rstn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .req_cpu_i, .req_gfx_i, .req_disp_lo_i, .req_disp_hi_i, .grant_o, .access_addr_i,
    .phys_addr_o, .cmd_start_i, .cs_allow_o, .read_bypass_i, .read_bypass_ok_o, .read_capture_o,
    .rfsh_pending_o, .rfsh_bank_o, .rfsh_done_i, .mode_set_o, .cas_latency_o, .sdclk_run_o,
    .sdclk_rise_o, .clk_out_en_o, .data_drive_strength_o, .address_bank_drive_strength_o,
    .control_drive_strength_o, .memory_clock_drive_strength_o, .two_module_banks_o, .one_component_bank_o);
  memory_side_model far_side (.clock_i, .rstn_i, .rfsh_pending_i(rfsh_pending_o),
    .answer_delay_i(answer_delay), .rfsh_done_o(rfsh_done_i));

  always #5 clock_i = ~clock_i;

  // refresh watcher: bank starts, spacing and one bank at a time
  always @(negedge clock_i) begin
    cb = (rfsh_pending_o === 1'b1) ? rfsh_bank_o : 2'b00;
    cyc = int'($time / 10);
    if (pb == 2'b01 && cb != 2'b01) te0 = cyc;
    if (cb != pb && cb == 2'b01) begin
      r0++;
      gap0 = cyc - t0;
      t0 = cyc;
    end
    if (cb != pb && cb == 2'b10) begin
      r1++;
      g01 = cyc - te0;
    end
    if (rfsh_pending_o === 1'b1 && !$onehot(rfsh_bank_o)) bad++;
    pb = cb;
  end

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clock_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clock_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    @(negedge clock_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge clock_i);
    `CHK(reg_rdata_o, e)
    @(negedge clock_i);
    reg_rd_i = 1'b0;
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge clock_i);
  endtask
  // cycles spanned by two sdram clock periods
  task automatic two_periods(output int c);
    int m;
    m = 0;
    idle(12);
    while (sdclk_rise_o !== 1'b1 && m < 40) begin
      @(negedge clock_i);
      m++;
    end
    c = 0;
    m = 0;
    while (m < 2 && c < 40) begin
      @(negedge clock_i);
      c++;
      if (sdclk_rise_o === 1'b1) m++;
    end
  endtask
  task automatic first_rise(input logic [2:0] s, output int c);
    wr(OFF_CTRL_TWO, {26'h0, s, 3'h0});
    wr(OFF_CTRL_ONE, 32'h00040000);
    wr(OFF_CTRL_ONE, 32'h00060000);
    c = 0;
    do begin
      @(negedge clock_i);
      c++;
    end while (sdclk_rise_o !== 1'b1 && c < 30);
  endtask
  task automatic capture_gap(output int c);
    c = 0;
    while (sdclk_rise_o !== 1'b1 && c < 30) begin
      @(negedge clock_i);
      c++;
    end
    c = 0;
    do begin
      @(negedge clock_i);
      c++;
    end while (read_capture_o !== 1'b1 && c < 30);
  endtask
  task automatic count_mode(output int c);
    c = 0;
    repeat (8) begin
      @(negedge clock_i);
      if (mode_set_o === 1'b1) c++;
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd_chk(OFF_CTRL_ONE, RST_CTRL_ONE);
    rd_chk(OFF_CTRL_TWO, RST_CTRL_TWO);
    rd_chk(OFF_BANK_CFG, RST_BANK_CFG);
    rd_chk(OFF_TIMING_ONE, RST_TIMING_ONE);
    rd_chk(OFF_DIRTY_IDX, RST_ZERO);
    wr(16'h8410, 32'hffffffff);
    rd_chk(16'h8410, RST_ZERO);
    rd_chk(OFF_GFX_BASE, RST_ZERO);
    `CHK(sdclk_run_o, 1'b0)
    `CHK(clk_out_en_o, 5'h00)
  endtask
  task automatic t_clock;
    wr(OFF_CTRL_ONE, 32'h00040000);
    idle(3);
    `CHK(sdclk_run_o, 1'b0)
    wr(OFF_CTRL_ONE, 32'h00060000);
    idle(1);
    `CHK(sdclk_run_o, 1'b1)
    for (int c = 2; c < 8; c++) begin
      wr(OFF_CTRL_ONE, {11'h0, c[2:0], 18'h0});
      two_periods(n);
      `CHK(n, c + 2)
      wr(OFF_CTRL_ONE, {11'h0, c[2:0], 1'b1, 17'h0});
      two_periods(n);
      `CHK(n, c + 3)
    end
    first_rise(3'h0, n);
    first_rise(3'h4, k);
    `CHK(k - n, 2)
    first_rise(3'h6, k);
    `CHK(k - n, 3)
    first_rise(3'h7, k);
    `CHK(k - n, 0)
  endtask
  task automatic t_drive;
    wr(OFF_CTRL_ONE, 32'hca060000);
    rd_chk(OFF_CTRL_ONE, 32'hca060000);
    `CHK({data_drive_strength_o, address_bank_drive_strength_o, control_drive_strength_o}, 6'h36)
    wr(OFF_CTRL_TWO, 32'h00001583);
    `CHK(memory_clock_drive_strength_o, 2'h1)
    `CHK(clk_out_en_o, 5'h09)
    `CHK(read_bypass_ok_o, 1'b0)
    capture_gap(n);
    `CHK(n, 2)
    wr(OFF_CTRL_TWO, 32'h00000000);
    `CHK(clk_out_en_o, 5'h1f)
    `CHK(read_bypass_ok_o, 1'b1)
    read_bypass_i = 1'b0;
    #1 `CHK(read_bypass_ok_o, 1'b0)
    read_bypass_i = 1'b1;
    capture_gap(n);
    `CHK(n, 1)
    wr(OFF_BANK_CFG, 32'h00705000);
    `CHK({two_module_banks_o, one_component_bank_o}, 2'h3)
    wr(OFF_BANK_CFG, 32'h00700000);
    `CHK({two_module_banks_o, one_component_bank_o}, 2'h0)
    wr(OFF_GFX_BASE, 32'h0003a5c3);
    rd_chk(OFF_GFX_BASE, 32'h0003a5c3);
  endtask
  task automatic t_mode;
    wr(OFF_TIMING_ONE, 32'h5a733225);
    wr(OFF_CTRL_ONE, 32'h00060001);
    count_mode(n);
    `CHK(n, 1)
    `CHK(cas_latency_o, 3'h5)
    wr(OFF_TIMING_ONE, 32'h7a733225);
    wr(OFF_CTRL_ONE, 32'h00060001);
    count_mode(n);
    `CHK(n, 0)
    `CHK(cas_latency_o, 3'h5)
    wr(OFF_CTRL_ONE, 32'h00060000);
  endtask
  task automatic t_refresh;
    r0 = 0;
    r1 = 0;
    bad = 0;
    idle(60);
    `CHK(r0, 0)
    wr(OFF_CTRL_ONE, 32'h00060010);
    idle(40);
    `CHK(r0, 1)
    `CHK(r1, 1)
    answer_delay = 4'h5;
    wr(OFF_CTRL_ONE, 32'h000628c0);
    idle(130);
    `CHK(gap0, 40)
    k = g01;
    wr(OFF_CTRL_ONE, 32'h00062800);
    idle(130);
    `CHK((k - g01) inside {[7:9]}, 1'b1)
    `CHK(bad, 0)
    wr(OFF_CTRL_ONE, 32'h00060000);
    idle(40);
    r0 = 0;
    idle(100);
    `CHK(r0, 0)
  endtask
  task automatic t_arb;
    @(negedge clock_i);
    {req_disp_hi_i, req_disp_lo_i, req_gfx_i, req_cpu_i} = 4'hf;
    #1 `CHK(grant_o, 4'h8)
    @(negedge clock_i);
    req_disp_hi_i = 1'b0;
    #1 `CHK(grant_o, 4'h1)
    wr(OFF_CTRL_ONE, 32'h00060008);
    seen = 4'h0;
    repeat (3) begin
      @(negedge clock_i);
      seen = seen | grant_o;
      `CHK($onehot(grant_o), 1'b1)
    end
    `CHK(seen, 4'h7)
    req_disp_hi_i = 1'b1;
    #1 `CHK(grant_o, 4'h8)
    @(negedge clock_i);
    {req_disp_hi_i, req_disp_lo_i, req_gfx_i, req_cpu_i} = 4'h0;
  endtask
  task automatic t_map;
    wr(OFF_CTRL_ONE, 32'h00060004);
    access_addr_i = 32'h00401234;
    @(negedge clock_i);
    `CHK(phys_addr_o, 32'h000a1234)
    access_addr_i = 32'h0041fffc;
    @(negedge clock_i);
    `CHK(phys_addr_o, 32'h000bfffc)
    access_addr_i = 32'h00420000;
    @(negedge clock_i);
    `CHK(phys_addr_o, 32'h00420000)
    wr(OFF_CTRL_ONE, 32'h00060000);
    access_addr_i = 32'h00401234;
    cmd_start_i = 1'b1;
    #1 `CHK(cs_allow_o, 1'b1)
    @(negedge clock_i);
    `CHK(phys_addr_o, 32'h00401234)
    cmd_start_i = 1'b0;
    wr(OFF_CTRL_ONE, 32'h00060020);
    cmd_start_i = 1'b1;
    #1 `CHK(cs_allow_o, 1'b0)
    @(negedge clock_i);
    `CHK(cs_allow_o, 1'b1)
    cmd_start_i = 1'b0;
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    idle(10);
    rstn_i = 1'b1;
    t_reset();
    t_clock();
    t_drive();
    t_mode();
    t_refresh();
    t_arb();
    t_map();
    summarize();
  end
  // whole run needs about a thousand cycles; this bound cuts a hang short
  initial begin
    repeat (20000) @(posedge clock_i);
    failures++;
    summarize();
  end
endmodule
